// File: hw/gpgh_pkg.sv
package gpgh_pkg;

    // ----------------------------------------------------------------
    // Widths and register map
    // ----------------------------------------------------------------
    localparam int GPGH_H_W = 8;
    localparam int GPGH_G_W = 6;
    localparam int GPGH_G_DIR_W = 5;
    localparam int GPGH_EMI_W = 4;
    localparam int GPGH_MASTER_CLEAR_INPUT_BIT = 5;

    localparam logic [11:0] GPGH_G_PINS_OFS = 12'h000;
    localparam logic [11:0] GPGH_G_LAT_OFS = 12'h004;
    localparam logic [11:0] GPGH_G_DIR_OFS = 12'h008;
    localparam logic [11:0] GPGH_H_PINS_OFS = 12'h00c;
    localparam logic [11:0] GPGH_H_LAT_OFS = 12'h010;
    localparam logic [11:0] GPGH_H_DIR_OFS = 12'h014;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] GPGH_H_DIR_RST = 8'hff;
    localparam logic [7:0] GPGH_H_LAT_RST = 8'h00;
    localparam logic [4:0] GPGH_G_DIR_RST = 5'h1f;
    localparam logic [4:0] GPGH_G_LAT_RST = 5'h00;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic en;
        logic val;
    } gpgh_drv_type;

    typedef struct packed {
        gpgh_drv_type ccp3;
        gpgh_drv_type pwm3a;
        logic pwm3_tri;
        gpgh_drv_type ser_tx;
        gpgh_drv_type ser_dt;
        gpgh_drv_type ccp_four;
        gpgh_drv_type pwm3d;
        gpgh_drv_type ccp_five;
        gpgh_drv_type pwm1d;
        logic pwm1_tri;
    } gpgh_galt_type;

    typedef struct packed {
        logic en;
        logic [3:0] addr;
    } gpgh_emi_type;

    typedef struct packed {
        logic oe_n;
        logic val;
    } gpgh_pad_type;

    // Output selection of a shared pin: primary function, then the
    // enhanced PWM channel (which may float on shutdown), then the latch
    function automatic gpgh_pad_type gpgh_pick(logic dir, gpgh_drv_type hi,
                                               gpgh_drv_type lo, logic lo_tri,
                                               logic lat);
        gpgh_pad_type p;
        p.oe_n = dir;
        p.val = lat;
        if (!dir)
        begin
            if (hi.en)
            begin
                p.val = hi.val;
            end
            else if (lo.en)
            begin
                p.val = lo.val;
                p.oe_n = lo_tri;
            end
        end
        return p;
    endfunction

endpackage

// File: hw/gpgh_port_io.sv
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ns
module gpgh_port_io
    import gpgh_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [GPGH_G_W-1:0] port_g_pin_in,
    output logic [GPGH_G_W-1:0] port_g_pin_out,
    output logic [GPGH_G_W-1:0] port_g_oe_n_out,
    input wire logic [GPGH_H_W-1:0] port_h_pin_in,
    output logic [GPGH_H_W-1:0] port_h_pin_out,
    output logic [GPGH_H_W-1:0] port_h_oe_n_out,
    input wire gpgh_galt_type galt_in,
    input wire gpgh_emi_type emi_in,
    input wire logic master_clear_enable_cfg_in,
    output logic [GPGH_G_W-1:0] port_g_sync_out,
    output logic master_clear_n_out
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [GPGH_G_W-1:0] g_sync;
    logic [GPGH_H_W-1:0] h_sync;

    gpgh_sync #(.W(GPGH_G_W)) u_g_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .d_in(port_g_pin_in),
        .q_out(g_sync)
    );

    gpgh_sync #(.W(GPGH_H_W)) u_h_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .d_in(port_h_pin_in),
        .q_out(h_sync)
    );

    // ----------------------------------------------------------------
    // Register file over APB
    // ----------------------------------------------------------------
    logic [GPGH_H_W-1:0] port_h_latch_r, port_h_latch_nxt;
    logic [GPGH_H_W-1:0] port_h_direction_r, port_h_direction_nxt;
    logic [GPGH_G_DIR_W-1:0] port_g_latch_r, port_g_latch_nxt;
    logic [GPGH_G_DIR_W-1:0] port_g_direction_r, port_g_direction_nxt;
    logic pready_r, pready_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [GPGH_G_W-1:0] port_g_pins;
    logic acc;
    logic wr;

    assign acc = psel && penable && !pready_r;
    assign wr = psel && penable && pready_r && pwrite;
    // Pin 5 reads as data only while it is not the master clear input
    assign port_g_pins = {g_sync[GPGH_MASTER_CLEAR_INPUT_BIT] && !master_clear_enable_cfg_in,
                          g_sync[GPGH_MASTER_CLEAR_INPUT_BIT-1:0]};

    always_comb
    begin
        port_h_latch_nxt = port_h_latch_r;
        port_h_direction_nxt = port_h_direction_r;
        port_g_latch_nxt = port_g_latch_r;
        port_g_direction_nxt = port_g_direction_r;
        pready_nxt = acc;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        if (acc)
        begin
            prdata_nxt = 32'h0000_0000;
            unique case (paddr)
                GPGH_G_PINS_OFS: prdata_nxt[GPGH_G_W-1:0] = port_g_pins;
                GPGH_G_LAT_OFS: prdata_nxt[GPGH_G_DIR_W-1:0] = port_g_latch_r;
                GPGH_G_DIR_OFS: prdata_nxt[GPGH_G_DIR_W-1:0] = port_g_direction_r;
                GPGH_H_PINS_OFS: prdata_nxt[GPGH_H_W-1:0] = h_sync;
                GPGH_H_LAT_OFS: prdata_nxt[GPGH_H_W-1:0] = port_h_latch_r;
                GPGH_H_DIR_OFS: prdata_nxt[GPGH_H_W-1:0] = port_h_direction_r;
                default: pslverr_nxt = 1'b1;
            endcase
            if (pwrite)
            begin
                prdata_nxt = prdata_r;
            end
        end
        if (wr)
        begin
            unique case (paddr)
                // Writing the pins register loads the latch
                GPGH_G_PINS_OFS, GPGH_G_LAT_OFS:
                    port_g_latch_nxt = pwdata[GPGH_G_DIR_W-1:0];
                GPGH_G_DIR_OFS: port_g_direction_nxt = pwdata[GPGH_G_DIR_W-1:0];
                GPGH_H_PINS_OFS, GPGH_H_LAT_OFS:
                    port_h_latch_nxt = pwdata[GPGH_H_W-1:0];
                GPGH_H_DIR_OFS: port_h_direction_nxt = pwdata[GPGH_H_W-1:0];
                default: port_h_latch_nxt = port_h_latch_r;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            port_h_latch_r <= GPGH_H_LAT_RST;
            port_h_direction_r <= GPGH_H_DIR_RST;
            port_g_latch_r <= GPGH_G_LAT_RST;
            port_g_direction_r <= GPGH_G_DIR_RST;
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            port_h_latch_r <= port_h_latch_nxt;
            port_h_direction_r <= port_h_direction_nxt;
            port_g_latch_r <= port_g_latch_nxt;
            port_g_direction_r <= port_g_direction_nxt;
            pready_r <= pready_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    // ----------------------------------------------------------------
    // Pin output multiplexers
    // ----------------------------------------------------------------
    logic [GPGH_G_W-1:0] g_val_r, g_val_nxt, g_oe_n_r, g_oe_n_nxt;
    logic [GPGH_H_W-1:0] h_val_r, h_val_nxt, h_oe_n_r, h_oe_n_nxt;
    logic master_clear_input_n_r, master_clear_input_n_nxt;
    gpgh_pad_type pad0, pad1, pad2, pad3, pad4;
    gpgh_drv_type none;

    always_comb
    begin
        none = '0;
        pad0 = gpgh_pick(port_g_direction_r[0], galt_in.ccp3, galt_in.pwm3a,
                         galt_in.pwm3_tri, port_g_latch_r[0]);
        pad1 = gpgh_pick(port_g_direction_r[1], galt_in.ser_tx, none, 1'b0,
                         port_g_latch_r[1]);
        pad2 = gpgh_pick(port_g_direction_r[2], none, none, 1'b0, port_g_latch_r[2]);
        if (galt_in.ser_dt.en)
        begin
            pad2 = '{oe_n: 1'b0, val: galt_in.ser_dt.val};
        end
        pad3 = gpgh_pick(port_g_direction_r[3], galt_in.ccp_four, galt_in.pwm3d,
                         galt_in.pwm3_tri, port_g_latch_r[3]);
        pad4 = gpgh_pick(port_g_direction_r[4], galt_in.ccp_five, galt_in.pwm1d,
                         galt_in.pwm1_tri, port_g_latch_r[4]);
        g_val_nxt = {1'b0, pad4.val, pad3.val, pad2.val, pad1.val, pad0.val};
        g_oe_n_nxt = {1'b1, pad4.oe_n, pad3.oe_n, pad2.oe_n, pad1.oe_n, pad0.oe_n};
        h_val_nxt = port_h_latch_r;
        h_oe_n_nxt = port_h_direction_r;
        if (emi_in.en)
        begin
            h_val_nxt[GPGH_EMI_W-1:0] = emi_in.addr;
            h_oe_n_nxt[GPGH_EMI_W-1:0] = '0;
        end
        master_clear_input_n_nxt = master_clear_enable_cfg_in ? g_sync[GPGH_MASTER_CLEAR_INPUT_BIT] : 1'b1;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            g_val_r <= '0;
            g_oe_n_r <= '1;
            h_val_r <= '0;
            h_oe_n_r <= '1;
            master_clear_input_n_r <= 1'b1;
        end
        else
        begin
            g_val_r <= g_val_nxt;
            g_oe_n_r <= g_oe_n_nxt;
            h_val_r <= h_val_nxt;
            h_oe_n_r <= h_oe_n_nxt;
            master_clear_input_n_r <= master_clear_input_n_nxt;
        end
    end

    assign port_g_pin_out = g_val_r;
    assign port_g_oe_n_out = g_oe_n_r;
    assign port_h_pin_out = h_val_r;
    assign port_h_oe_n_out = h_oe_n_r;
    assign port_g_sync_out = g_sync;
    assign master_clear_n_out = master_clear_input_n_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    h_input_float_a: assert property (
        (!emi_in.en && port_h_direction_r[7]) |=> port_h_oe_n_out[7])
        else $error("H pin 7 driven while set as input");
    h_output_drive_a: assert property (
        !emi_in.en |=> (port_h_oe_n_out == $past(port_h_direction_r)
            && port_h_pin_out == $past(port_h_latch_r)))
        else $error("H pins not driving their latch");
    h_pins_read_a: assert property (
        (acc && !pwrite && paddr == GPGH_H_PINS_OFS)
            |=> (prdata[7:0] == $past(h_sync) && prdata[31:8] == '0))
        else $error("H pins read wrong");
    h_latch_read_a: assert property (
        (acc && !pwrite && paddr == GPGH_H_LAT_OFS)
            |=> (pready && prdata[7:0] == $past(port_h_latch_r) && prdata[31:8] == '0))
        else $error("H latch read wrong");
    h_dir_write_a: assert property (
        (wr && paddr == GPGH_H_DIR_OFS) |=> port_h_direction_r == $past(pwdata[7:0]))
        else $error("H direction write lost");
    h_reset_input_a: assert property (
        @(posedge ref_clk_in) $past(rst_in) |-> (port_h_oe_n_out == 8'hff
            && port_h_direction_r == GPGH_H_DIR_RST))
        else $error("H pins not inputs after reset");
    emi_address_a: assert property (
        emi_in.en |=> (port_h_oe_n_out[3:0] == 4'h0
            && port_h_pin_out[3:0] == $past(emi_in.addr)))
        else $error("Memory address not on H pins");
    ser_tx_drive_a: assert property (
        (!port_g_direction_r[1] && galt_in.ser_tx.en)
            |=> (!port_g_oe_n_out[1] && port_g_pin_out[1] == $past(galt_in.ser_tx.val)))
        else $error("Serial transmit not on G pin 1");
    g_dir_input_a: assert property (
        port_g_direction_r[1] |=> port_g_oe_n_out[1])
        else $error("G pin 1 driven while set as input");
    g_input_sync_a: assert property (
        !$past(rst_in) && !$past(rst_in, 2) |-> port_g_sync_out == $past(port_g_pin_in, 2))
        else $error("G input not two stages late");
    ser_dt_drive_a: assert property (
        galt_in.ser_dt.en |=> (!port_g_oe_n_out[2]
            && port_g_pin_out[2] == $past(galt_in.ser_dt.val)))
        else $error("Serial data not on G pin 2");
    ccp_four_prio_a: assert property (
        (!port_g_direction_r[3] && galt_in.ccp_four.en)
            |=> (!port_g_oe_n_out[3] && port_g_pin_out[3] == $past(galt_in.ccp_four.val)))
        else $error("CCP_FOUR lost G pin 3");
    ccp_five_prio_a: assert property (
        (!port_g_direction_r[4] && galt_in.ccp_five.en)
            |=> (!port_g_oe_n_out[4] && port_g_pin_out[4] == $past(galt_in.ccp_five.val)))
        else $error("CCP_FIVE lost G pin 4");
    pwm_shutdown_a: assert property (
        (!port_g_direction_r[3] && !galt_in.ccp_four.en && galt_in.pwm3d.en)
            |=> (port_g_oe_n_out[3] == $past(galt_in.pwm3_tri)))
        else $error("PWM3 channel D tri-state wrong");
    pwm1_shutdown_a: assert property (
        (!port_g_direction_r[4] && !galt_in.ccp_five.en && galt_in.pwm1d.en)
            |=> (port_g_oe_n_out[4] == $past(galt_in.pwm1_tri)
            && port_g_pin_out[4] == $past(galt_in.pwm1d.val)))
        else $error("PWM1 channel D drive wrong");
    pwm3a_shutdown_a: assert property (
        (!port_g_direction_r[0] && !galt_in.ccp3.en && galt_in.pwm3a.en)
            |=> (port_g_oe_n_out[0] == $past(galt_in.pwm3_tri)))
        else $error("PWM3 channel A tri-state wrong");
    master_clear_input_select_a: assert property (
        master_clear_enable_cfg_in |=> master_clear_n_out == $past(g_sync[5]))
        else $error("Master clear not following pin 5");
    master_clear_input_off_a: assert property (
        !master_clear_enable_cfg_in |=> master_clear_n_out)
        else $error("Master clear active while disabled");
    pin5_read_a: assert property (
        (acc && !pwrite && paddr == GPGH_G_PINS_OFS && master_clear_enable_cfg_in)
            |=> !prdata[GPGH_MASTER_CLEAR_INPUT_BIT])
        else $error("G pin 5 read as data while master clear");
    pin5_input_a: assert property (
        port_g_oe_n_out[5] && !port_g_pin_out[5])
        else $error("G pin 5 driven");
    ccp3_drive_a: assert property (
        (!port_g_direction_r[0] && galt_in.ccp3.en)
            |=> (!port_g_oe_n_out[0] && port_g_pin_out[0] == $past(galt_in.ccp3.val)))
        else $error("CCP3 not on G pin 0");

    h_write_c: cover property (wr && paddr == GPGH_H_LAT_OFS);
    emi_on_c: cover property (emi_in.en ##1 !emi_in.en);
    ser_dt_c: cover property (galt_in.ser_dt.en && port_g_direction_r[2]);
    slverr_c: cover property (pslverr);
endmodule

// File: hw/gpgh_sync.sv
`timescale 1ns/1ns
module gpgh_sync #(
    parameter int W = 8
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // Two-stage synchroniser, first stage read only by the second
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            // Pins idle high: a zero here would fake a master clear after reset
            meta_r <= '1;
            q_r <= '1;
        end
        else
        begin
            meta_r <= d_in;
            q_r <= meta_r;
        end
    end

    assign q_out = q_r;
endmodule

// File: tb/gpgh_board.sv
`timescale 1ns/1ns
module gpgh_board
    import gpgh_pkg::*;
(
    input wire logic [GPGH_G_W-1:0] g_drv_in,
    input wire logic [GPGH_G_W-1:0] g_oe_n_in,
    input wire logic [GPGH_G_W-1:0] g_src_en_in,
    input wire logic [GPGH_G_W-1:0] g_src_in,
    output logic [GPGH_G_W-1:0] g_pin_out,
    input wire logic [GPGH_H_W-1:0] h_drv_in,
    input wire logic [GPGH_H_W-1:0] h_oe_n_in,
    input wire logic [GPGH_H_W-1:0] h_src_en_in,
    input wire logic [GPGH_H_W-1:0] h_src_in,
    output logic [GPGH_H_W-1:0] h_pin_out
);
    // ----------------------------------------------------------------
    // Wire level: device driver, else board source, else pull-up
    // ----------------------------------------------------------------
    assign g_pin_out = (~g_oe_n_in & g_drv_in) | (g_oe_n_in & (~g_src_en_in | g_src_in));
    assign h_pin_out = (~h_oe_n_in & h_drv_in) | (h_oe_n_in & (~h_src_en_in | h_src_in));
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench
    import gpgh_pkg::*;
;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, mc_n;
    logic [31:0] prdata, rd;
    logic er;
    logic [5:0] g_in, g_out, g_oe_n, g_sync;
    logic [5:0] g_xen = 6'h00;
    logic [5:0] g_xv = 6'h00;
    logic [7:0] h_in, h_out, h_oe_n;
    logic [7:0] h_xen = 8'h00;
    logic [7:0] h_xv = 8'h00;
    gpgh_galt_type galt = '0;
    gpgh_emi_type emi = '0;
    logic mc_cfg = 1'b0;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;

    always #4 ref_clk_in = ~ref_clk_in;

    gpgh_port_io dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .port_g_pin_in(g_in),
        .port_g_pin_out(g_out), .port_g_oe_n_out(g_oe_n), .port_h_pin_in(h_in),
        .port_h_pin_out(h_out), .port_h_oe_n_out(h_oe_n), .galt_in(galt), .emi_in(emi),
        .master_clear_enable_cfg_in(mc_cfg), .port_g_sync_out(g_sync),
        .master_clear_n_out(mc_n));

    gpgh_board board (.g_drv_in(g_out), .g_oe_n_in(g_oe_n), .g_src_en_in(g_xen),
        .g_src_in(g_xv), .g_pin_out(g_in), .h_drv_in(h_out), .h_oe_n_in(h_oe_n),
        .h_src_en_in(h_xen), .h_src_in(h_xv), .h_pin_out(h_in));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task results();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk_in);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "read");
    endtask

    task tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    always @(posedge ref_clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_count++;
            results();
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        gpgh_galt_type g;
        tick(16);
        chk(h_oe_n, 32'hff, "h oe in reset");
        rst_in <= 1'b0;
        rd_chk(GPGH_H_DIR_OFS, 32'hff);
        rd_chk(GPGH_H_LAT_OFS, 32'h00);
        rd_chk(GPGH_G_DIR_OFS, 32'h1f);
        rd_chk(GPGH_G_LAT_OFS, 32'h00);
        apb(1'b0, 12'hffc, 32'h0);
        chk(er, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        h_xen <= 8'hff;
        h_xv <= 8'h3c;
        apb(1'b1, GPGH_H_LAT_OFS, 32'ha5);
        apb(1'b1, GPGH_H_DIR_OFS, 32'hcf);
        tick(2);
        chk(h_oe_n, 32'hcf, "h oe");
        chk(h_out & 8'h30, 32'h20, "h out");
        rd_chk(GPGH_H_PINS_OFS, 32'h2c);
        rd_chk(GPGH_H_LAT_OFS, 32'ha5);
        emi <= '{en: 1'b1, addr: 4'h6};
        tick(2);
        chk({h_oe_n, h_out[3:0]}, {8'hc0, 4'h6}, "emi");
        emi <= '0;
        apb(1'b1, GPGH_G_LAT_OFS, 32'h1f);
        apb(1'b1, GPGH_G_DIR_OFS, 32'h00);
        g = '0;
        g.ccp3 = 2'b10;
        g.pwm3a = 2'b11;
        g.ser_tx = 2'b10;
        g.ccp_four = 2'b10;
        g.pwm3d = 2'b11;
        g.ccp_five = 2'b10;
        g.pwm1d = 2'b11;
        galt <= g;
        tick(2);
        chk({g_oe_n[4:0], g_out[4:0]}, {5'h00, 5'h04}, "g prio");
        g = '0;
        g.pwm3a = 2'b10;
        g.pwm3_tri = 1'b1;
        g.pwm3d = 2'b10;
        g.pwm1d = 2'b10;
        galt <= g;
        tick(2);
        chk({g_oe_n[4:0], g_out[4]}, {5'h09, 1'b0}, "pwm");
        apb(1'b1, GPGH_G_DIR_OFS, 32'h3f);
        rd_chk(GPGH_G_DIR_OFS, 32'h1f);
        g = '0;
        g.ser_dt = 2'b10;
        g.ccp3 = 2'b10;
        galt <= g;
        tick(2);
        chk({g_oe_n, g_out[2]}, {6'h3b, 1'b0}, "sync data");
        galt <= '0;
        g_xen <= 6'h3f;
        g_xv <= 6'h2a;
        tick(3);
        chk({g_sync, mc_n}, {6'h2a, 1'b1}, "g in");
        rd_chk(GPGH_G_PINS_OFS, 32'h2a);
        mc_cfg <= 1'b1;
        tick(3);
        chk(mc_n, 32'h1, "master_clear_input high");
        rd_chk(GPGH_G_PINS_OFS, 32'h0a);
        g_xv <= 6'h0a;
        tick(4);
        chk(mc_n, 32'h0, "master_clear_input low");
        results();
    end
endmodule
